// [hdl/sag_pkg.sv]
// Constants, codes and helper functions of the store address generator
package sag_pkg;
  localparam int AXI_AW = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [11:0] REG_INSTR = 12'h000;
  localparam logic [11:0] REG_MODE_CTRL = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_LAST_ADDR = 12'h00C;
  localparam logic [11:0] REG_COUNT = 12'h010;
  localparam logic [11:0] REG_RFA_BASE = 12'h100;
  localparam logic [11:0] REG_RFB_BASE = 12'h180;
  localparam int RF_PAGE_LSB = 7;
  // Reset values
  localparam logic [31:0] MODE_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  // Status bit positions
  localparam int ST_BAD_TYPE_BIT = 0;
  localparam int ST_MISALIGN_BIT = 1;
  // Instruction word field positions
  localparam int F_CREG_LSB = 29;
  localparam int F_Z_BIT = 28;
  localparam int F_SRC_LSB = 23;
  localparam int F_BASE_LSB = 18;
  localparam int F_OFF_LSB = 13;
  localparam int F_MODE_LSB = 9;
  localparam int F_LCST_LSB = 8;
  localparam int F_Y_BIT = 7;
  localparam int F_TYPE_LSB = 4;
  localparam int F_FORM_LSB = 2;
  localparam int F_S_BIT = 1;
  // Address-mode field bits
  localparam int MODE_UPDATE_BIT = 3;
  localparam int MODE_REG_BIT = 2;
  localparam int MODE_POST_BIT = 1;
  localparam int MODE_ADD_BIT = 0;
  // Store-type and form codes
  localparam logic [2:0] ST_BYTE = 3'h3;
  localparam logic [2:0] ST_HALF = 3'h5;
  localparam logic [2:0] ST_WORD = 3'h7;
  localparam logic [1:0] FORM_SHORT = 2'h1;
  localparam logic [1:0] FORM_LONG = 2'h3;
  localparam logic [4:0] LONG_BASE_Y0 = 5'hE;
  localparam logic [4:0] LONG_BASE_Y1 = 5'hF;
  // Circular addressing controls
  localparam logic [4:0] CIRC_FIRST = 5'h4;
  localparam logic [4:0] CIRC_LAST = 5'h7;
  localparam int MC_BLK0_LSB = 16;
  localparam int MC_BLK1_LSB = 21;
  localparam logic [1:0] MC_CIRC0 = 2'h1;
  localparam logic [1:0] MC_CIRC1 = 2'h2;

  function automatic logic [1:0] sag_size_shift(input logic [2:0] st_type);
    case (st_type)
      ST_HALF: sag_size_shift = 2'h1;
      ST_WORD: sag_size_shift = 2'h2;
      default: sag_size_shift = 2'h0;
    endcase
  endfunction : sag_size_shift

  // Block of 2^(exp+1) bytes; exp 31 spans the whole space
  function automatic logic [31:0] sag_blk_mask(input logic [4:0] blk_exp);
    logic [32:0] wide;
    wide = (33'h1 << ({1'b0, blk_exp} + 6'h1)) - 33'h1;
    sag_blk_mask = wide[31:0];
  endfunction : sag_blk_mask

  function automatic logic [31:0] sag_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old_val[8*i +: 8] = strb[i] ? new_val[8*i +: 8] : old_val[8*i +: 8];
    end
    sag_merge = old_val;
  endfunction : sag_merge
endpackage : sag_pkg

// [hdl/sag_addr_gen.sv]
// Address arithmetic: scaling, add or subtract, circular wrap, pre or post select
`timescale 1ns/1ps
module sag_addr_gen
  import sag_pkg::*;
(
  input logic [31:0] base,
  input logic [31:0] offset,
  input logic [1:0] shift,
  input logic add_sel,
  input logic post_sel,
  input logic circ_en,
  input logic [4:0] blk_exp,
  output logic [31:0] eff_addr,
  output logic [31:0] new_base
);
  logic [31:0] scaled;
  logic [31:0] sum;
  logic [31:0] mask;

  assign scaled = offset << shift;
  assign sum = add_sel ? base + scaled : base - scaled;
  assign mask = circ_en ? sag_blk_mask(blk_exp) : 32'hFFFF_FFFF;
  // Upper bits stay put in circular mode so the pointer wraps inside its block
  assign new_base = (base & ~mask) | (sum & mask);
  assign eff_addr = post_sel ? base : new_base;
endmodule : sag_addr_gen

// [hdl/sag_store_fmt.sv]
// Store data lane placement and byte strobes
`timescale 1ns/1ps
module sag_store_fmt
  import sag_pkg::*;
(
  input logic [31:0] src,
  input logic [1:0] shift,
  input logic [1:0] addr_lo,
  output logic [31:0] wdata,
  output logic [3:0] strb
);
  always_comb begin
    case (shift)
      2'h0: begin
        wdata = {4{src[7:0]}};
        strb = 4'h1 << addr_lo;
      end
      2'h1: begin
        wdata = {2{src[15:0]}};
        strb = addr_lo[1] ? 4'hC : 4'h3;
      end
      default: begin
        wdata = src;
        strb = 4'hF;
      end
    endcase
  end
endmodule : sag_store_fmt

// [hdl/sag_store_unit.sv]
// Store address generator with register files and AXI4-Lite access
`timescale 1ns/1ps
module sag_store_unit
  import sag_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [AXI_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [AXI_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic mem_valid,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_strb
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic issue;
    logic [31:0] instr;
    logic [31:0] addressing_mode_ctrl_reg;
    logic bad_type;
    logic misalign;
    logic [31:0] last_addr;
    logic [31:0] count;
    logic [31:0][31:0] rf_a;
    logic [31:0][31:0] rf_b;
    logic mem_valid;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [3:0] mem_strb;
  } sag_state_t;

  sag_state_t s_q;
  sag_state_t s_d;

  // Decode of the instruction held in the issue slot
  logic [31:0] ins;
  logic [2:0] st_type;
  logic [1:0] form;
  logic [3:0] mode;
  logic [4:0] base_idx;
  logic [4:0] src_idx;
  logic y_bit;
  logic long_form;
  logic type_ok;
  logic form_ok;
  logic cond_ok;
  logic fire;
  logic update;
  logic [1:0] shift;
  logic [31:0] base_val;
  logic [31:0] off_val;
  logic [31:0] long_base;
  logic [31:0] src_a;
  logic [31:0] src_b;
  logic [31:0] src_val;
  logic circ_reg;
  logic [1:0] circ_field;
  logic circ;
  logic [4:0] blk_exp;
  logic [31:0] eff_addr;
  logic [31:0] new_base;
  logic [31:0] fmt_data;
  logic [3:0] fmt_strb;
  logic [31:0] chk_scaled;

  assign ins = s_q.instr;
  assign st_type = ins[F_TYPE_LSB +: 3];
  assign form = ins[F_FORM_LSB +: 2];
  assign mode = ins[F_MODE_LSB +: 4];
  assign base_idx = ins[F_BASE_LSB +: 5];
  assign src_idx = ins[F_SRC_LSB +: 5];
  assign y_bit = ins[F_Y_BIT];
  assign long_form = (form == FORM_LONG);
  assign type_ok = (st_type == ST_BYTE) || (st_type == ST_HALF) || (st_type == ST_WORD);
  assign form_ok = long_form || (form == FORM_SHORT);
  assign shift = sag_size_shift(st_type);

  // Predicate: creg 0 is unconditional, 1 to 5 test B0, B1, B2, A1, A2
  always_comb begin
    case (ins[F_CREG_LSB +: 3])
      3'h1: cond_ok = (s_q.rf_b[0] != 32'h0);
      3'h2: cond_ok = (s_q.rf_b[1] != 32'h0);
      3'h3: cond_ok = (s_q.rf_b[2] != 32'h0);
      3'h4: cond_ok = (s_q.rf_a[1] != 32'h0);
      3'h5: cond_ok = (s_q.rf_a[2] != 32'h0);
      default: cond_ok = 1'b1;
    endcase
    if (ins[F_CREG_LSB +: 3] != 3'h0 && ins[F_Z_BIT]) begin
      cond_ok = !cond_ok;
    end
  end

  assign fire = s_q.issue && type_ok && form_ok && cond_ok;
  assign update = !long_form && mode[MODE_UPDATE_BIT];

  // Short form takes base and offset from the side of the chosen unit; long form takes its base from B14 or B15
  assign long_base = y_bit ? s_q.rf_b[LONG_BASE_Y1] : s_q.rf_b[LONG_BASE_Y0];
  always_comb begin
    if (long_form) begin
      base_val = long_base;
      off_val = {17'h0, ins[F_LCST_LSB +: 15]};
    end else begin
      base_val = y_bit ? s_q.rf_b[base_idx] : s_q.rf_a[base_idx];
      if (mode[MODE_REG_BIT]) begin
        off_val = y_bit ? s_q.rf_b[ins[F_OFF_LSB +: 5]] : s_q.rf_a[ins[F_OFF_LSB +: 5]];
      end else begin
        off_val = {27'h0, ins[F_OFF_LSB +: 5]};
      end
    end
  end

  assign src_a = s_q.rf_a[src_idx];
  assign src_b = s_q.rf_b[src_idx];
  assign src_val = ins[F_S_BIT] ? src_b : src_a;

  // Circular only for registers 4..7 whose mode-control field selects a block size
  assign circ_reg = (base_idx >= CIRC_FIRST) && (base_idx <= CIRC_LAST);
  assign circ_field = s_q.addressing_mode_ctrl_reg[{y_bit, base_idx[1:0], 1'b0} +: 2];
  assign circ = !long_form && circ_reg && (circ_field == MC_CIRC0 || circ_field == MC_CIRC1);
  assign blk_exp = (circ_field == MC_CIRC1) ? s_q.addressing_mode_ctrl_reg[MC_BLK1_LSB +: 5]
                                            : s_q.addressing_mode_ctrl_reg[MC_BLK0_LSB +: 5];

  sag_addr_gen u_addr (
    .base(base_val),
    .offset(off_val),
    .shift(shift),
    .add_sel(long_form || mode[MODE_ADD_BIT]),
    .post_sel(!long_form && mode[MODE_POST_BIT]),
    .circ_en(circ),
    .blk_exp(blk_exp),
    .eff_addr(eff_addr),
    .new_base(new_base)
  );

  sag_store_fmt u_fmt (
    .src(src_val),
    .shift(shift),
    .addr_lo(eff_addr[1:0]),
    .wdata(fmt_data),
    .strb(fmt_strb)
  );

  always_comb begin
    s_d = s_q;
    s_d.issue = 1'b0;
    s_d.mem_valid = 1'b0;
    // Write channels are taken independently, in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_addr[AXI_AW-1:RF_PAGE_LSB] == REG_RFA_BASE[AXI_AW-1:RF_PAGE_LSB]) begin
        s_d.rf_a[s_q.aw_addr[6:2]] = sag_merge(s_q.rf_a[s_q.aw_addr[6:2]], s_q.w_data, s_q.w_strb);
      end else if (s_q.aw_addr[AXI_AW-1:RF_PAGE_LSB] == REG_RFB_BASE[AXI_AW-1:RF_PAGE_LSB]) begin
        s_d.rf_b[s_q.aw_addr[6:2]] = sag_merge(s_q.rf_b[s_q.aw_addr[6:2]], s_q.w_data, s_q.w_strb);
      end else begin
        case ({s_q.aw_addr[AXI_AW-1:2], 2'h0})
          REG_INSTR: begin
            s_d.instr = sag_merge(s_q.instr, s_q.w_data, s_q.w_strb);
            s_d.issue = 1'b1;
          end
          REG_MODE_CTRL: begin
            s_d.addressing_mode_ctrl_reg = sag_merge(s_q.addressing_mode_ctrl_reg, s_q.w_data, s_q.w_strb);
          end
          REG_STATUS: begin
            if (s_q.w_strb[0]) begin
              s_d.bad_type = s_q.bad_type && !s_q.w_data[ST_BAD_TYPE_BIT];
              s_d.misalign = s_q.misalign && !s_q.w_data[ST_MISALIGN_BIT];
            end
          end
          REG_LAST_ADDR, REG_COUNT: ;
          default: s_d.bresp = RESP_SLVERR;
        endcase
      end
    end
    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      if (s_axi_araddr[AXI_AW-1:RF_PAGE_LSB] == REG_RFA_BASE[AXI_AW-1:RF_PAGE_LSB]) begin
        s_d.rdata = s_q.rf_a[s_axi_araddr[6:2]];
      end else if (s_axi_araddr[AXI_AW-1:RF_PAGE_LSB] == REG_RFB_BASE[AXI_AW-1:RF_PAGE_LSB]) begin
        s_d.rdata = s_q.rf_b[s_axi_araddr[6:2]];
      end else begin
        case ({s_axi_araddr[AXI_AW-1:2], 2'h0})
          REG_INSTR: s_d.rdata = s_q.instr;
          REG_MODE_CTRL: s_d.rdata = s_q.addressing_mode_ctrl_reg;
          REG_STATUS: begin
            s_d.rdata[ST_BAD_TYPE_BIT] = s_q.bad_type;
            s_d.rdata[ST_MISALIGN_BIT] = s_q.misalign;
          end
          REG_LAST_ADDR: s_d.rdata = s_q.last_addr;
          REG_COUNT: s_d.rdata = s_q.count;
          default: s_d.rresp = RESP_SLVERR;
        endcase
      end
    end
    // Execute stage; sets come after the software clear so an event is never lost
    if (s_q.issue && !(type_ok && form_ok)) begin
      s_d.bad_type = 1'b1;
    end
    if (fire) begin
      s_d.mem_valid = 1'b1;
      s_d.mem_addr = eff_addr;
      s_d.mem_wdata = fmt_data;
      s_d.mem_strb = fmt_strb;
      s_d.last_addr = eff_addr;
      s_d.count = s_q.count + 32'h1;
      // Alignment is the program's duty; a slip is only recorded
      if ((shift == 2'h2 && eff_addr[1:0] != 2'h0) || (shift == 2'h1 && eff_addr[0])) begin
        s_d.misalign = 1'b1;
      end
      // Write-back wins over a same-cycle software write to the same register
      if (update) begin
        if (y_bit) begin
          s_d.rf_b[base_idx] = new_base;
        end else begin
          s_d.rf_a[base_idx] = new_base;
        end
      end
    end
    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready = !s_d.w_full && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.addressing_mode_ctrl_reg <= MODE_CTRL_RESET;
      s_q.count <= COUNT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign mem_valid = s_q.mem_valid;
  assign mem_addr = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign mem_strb = s_q.mem_strb;

  // Reference scaled offset for the linear pre-address check
  assign chk_scaled = off_val << shift;

  chk_word_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_valid |-> ((mem_strb == 4'hF) == ($past(st_type) == ST_WORD)))
    else $error("word strobe does not match store type");

  chk_word_source: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && st_type == ST_WORD |=> mem_wdata == ($past(ins[F_S_BIT]) ? $past(src_b) : $past(src_a)))
    else $error("word data not taken from the selected file");

  chk_byte_lanes: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && st_type == ST_BYTE |=> mem_wdata == {4{$past(src_val[7:0])}} && $countones(mem_strb) == 1)
    else $error("byte store data or strobe wrong");

  chk_pre_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && !long_form && !circ && !mode[MODE_POST_BIT]
    |=> mem_addr == ($past(mode[MODE_ADD_BIT]) ? $past(base_val + chk_scaled) : $past(base_val - chk_scaled)))
    else $error("linear pre or offset address wrong");

  chk_post_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && !long_form && mode[MODE_POST_BIT] |=> mem_addr == $past(base_val))
    else $error("post mode did not send the old base");

  chk_long_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && long_form |=> mem_addr == $past(long_base + ({17'h0, ins[F_LCST_LSB +: 15]} << shift)))
    else $error("long constant address wrong");

  chk_circ_block: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && circ |=> (mem_addr & ~$past(sag_blk_mask(blk_exp))) == ($past(base_val) & ~$past(sag_blk_mask(blk_exp))))
    else $error("circular address left its block");

  chk_base_wb: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && update |=> ($past(y_bit) ? s_q.rf_b[$past(base_idx)] : s_q.rf_a[$past(base_idx)]) == $past(new_base))
    else $error("base register not updated");

  chk_cond_squash: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.issue && !cond_ok |=> !mem_valid && s_q.count == $past(s_q.count))
    else $error("store executed with false predicate");
endmodule : sag_store_unit

// [bench/sag_mem_sink.sv]
// Data memory model that records every store it receives
`timescale 1ns/1ps
module sag_mem_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_strb,
  output logic [31:0] seen_addr,
  output logic [31:0] seen_data,
  output logic [3:0] seen_strb,
  output int seen_cnt
);
  // Always ready: the store port carries no back-pressure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_cnt <= 0;
    end else if (mem_valid) begin
      seen_addr <= mem_addr;
      seen_data <= mem_wdata;
      seen_strb <= mem_strb;
      seen_cnt <= seen_cnt + 1;
    end
  end
endmodule : sag_mem_sink

// [bench/store_address_generator_tb.sv]
// Self-checking bench for the store address generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module store_address_generator_tb;
  import sag_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, mem_valid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, mem_addr, mem_wdata, s_addr, s_data, rd;
  logic [3:0] mem_strb, s_strb;
  int s_cnt;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  sag_store_unit i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_strb(mem_strb)
  );

  sag_mem_sink i_mem (
    .aclk(aclk), .aresetn(aresetn), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_strb(mem_strb), .seen_addr(s_addr), .seen_data(s_data),
    .seen_strb(s_strb), .seen_cnt(s_cnt)
  );

  always #50 aclk = ~aclk;

  // Whole run needs roughly 400 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  function automatic logic [11:0] fa(input logic [4:0] n);
    fa = REG_RFA_BASE + {5'h0, n, 2'h0};
  endfunction : fa

  function automatic logic [11:0] fb(input logic [4:0] n);
    fb = REG_RFB_BASE + {5'h0, n, 2'h0};
  endfunction : fb

  // Reserved bit always zero
  function automatic logic [31:0] enc(input logic [2:0] cr, input logic z, input logic [4:0] src,
                                      input logic [4:0] bs, input logic [4:0] off, input logic [3:0] md,
                                      input logic y, input logic [2:0] ty, input logic s);
    enc = {cr, z, src, bs, off, md, 1'b0, y, ty, FORM_SHORT, s, 1'b0};
  endfunction : enc

  // Store latency is fixed, so a fixed wait suffices
  task automatic issue(input logic [31:0] ins, input logic exp_st);
    int n0;
    n0 = s_cnt;
    wr(REG_INSTR, ins);
    `CHK("instr bresp", RESP_OKAY, resp)
    repeat (4) @(posedge aclk);
    `CHK("store count", n0 + int'(exp_st), s_cnt)
  endtask : issue

  task automatic t_reset;
    rd_reg(REG_MODE_CTRL);
    `CHK("mode ctrl", MODE_CTRL_RESET, rd)
    `CHK("mode ctrl rresp", RESP_OKAY, resp)
    rd_reg(12'h040);
    `CHK("unmapped rresp", RESP_SLVERR, resp)
    wr(12'h044, 32'h1);
    `CHK("unmapped bresp", RESP_SLVERR, resp)
  endtask : t_reset

  // Addresses kept aligned for half and word
  task automatic t_types;
    logic [2:0] ty [3] = '{ST_BYTE, ST_HALF, ST_WORD};
    logic [31:0] ed [3] = '{32'h4444_4444, 32'h3344_3344, 32'h1122_3344};
    logic [3:0] es [3] = '{4'h8, 4'hC, 4'hF};
    wr(fa(5'h3), 32'h0000_1000);
    wr(fb(5'h3), 32'h0000_8000);
    wr(fa(5'h2), 32'h0000_0003);
    wr(fb(5'h5), 32'h1122_3344);
    wr(fa(5'h5), 32'h5566_7788);
    for (int i = 0; i < 3; i++) begin
      issue(enc(3'h0, 1'b0, 5'h5, 5'h3, 5'h2, 4'h5, 1'b0, ty[i], 1'b1), 1'b1);
      `CHK("addr", 32'h1000 + (32'h3 << i), s_addr)
      `CHK("data", ed[i], s_data)
      `CHK("strb", es[i], s_strb)
    end
    issue(enc(3'h0, 1'b0, 5'h5, 5'h3, 5'h2, 4'h5, 1'b0, ST_WORD, 1'b0), 1'b1);
    `CHK("src a", 32'h5566_7788, s_data)
  endtask : t_types

  task automatic t_modes;
    logic [3:0] md [12] = '{4'h5, 4'h4, 4'hD, 4'hC, 4'hF, 4'hE, 4'h1, 4'h0, 4'h9, 4'h8, 4'hB, 4'hA};
    logic [31:0] sc, calc;
    wr(fb(5'h2), 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      wr(fb(5'h3), 32'h0000_2000);
      issue(enc(3'h0, 1'b0, 5'h5, 5'h3, 5'h2, md[i], 1'b1, ST_WORD, 1'b1), 1'b1);
      sc = (md[i][2] ? 32'h1 : 32'h2) << 2;
      calc = md[i][0] ? 32'h2000 + sc : 32'h2000 - sc;
      `CHK("mode addr", md[i][1] ? 32'h2000 : calc, s_addr)
      rd_reg(fb(5'h3));
      `CHK("base wb", md[i][3] ? calc : 32'h2000, rd)
    end
  endtask : t_modes

  task automatic t_long;
    wr(fb(5'hE), 32'h0001_0000);
    wr(fb(5'hF), 32'h0002_0000);
    for (int y = 0; y < 2; y++) begin
      issue({3'h0, 1'b0, 5'h5, 15'h4001, y[0], ST_HALF, FORM_LONG, 1'b0, 1'b0}, 1'b1);
      `CHK("long addr", (y ? 32'h2_0000 : 32'h1_0000) + 32'h8002, s_addr)
      `CHK("long data", 32'h7788_7788, s_data)
      `CHK("long strb", 4'hC, s_strb)
      rd_reg(y ? fb(5'hF) : fb(5'hE));
      `CHK("long base", y ? 32'h2_0000 : 32'h1_0000, rd)
    end
  endtask : t_long

  // Block of 16 bytes for the fifth A register; third one reads the seventh's field, also set circular, but stays linear
  task automatic t_circ;
    wr(REG_MODE_CTRL, 32'h0003_0044);
    wr(fa(5'h5), 32'h0000_4000);
    wr(fa(5'h3), 32'h0000_4000);
    issue(enc(3'h0, 1'b0, 5'h5, 5'h5, 5'h4, 4'h8, 1'b0, ST_BYTE, 1'b0), 1'b1);
    `CHK("circ addr", 32'h0000_400C, s_addr)
    issue(enc(3'h0, 1'b0, 5'h5, 5'h3, 5'h4, 4'h8, 1'b0, ST_BYTE, 1'b0), 1'b1);
    `CHK("lin addr", 32'h0000_3FFC, s_addr)
    wr(REG_MODE_CTRL, MODE_CTRL_RESET);
  endtask : t_circ

  task automatic t_pred;
    wr(fa(5'h1), 32'h0);
    wr(fa(5'h6), 32'h0000_0100);
    issue(enc(3'h4, 1'b0, 5'h5, 5'h6, 5'h1, 4'h9, 1'b0, ST_WORD, 1'b0), 1'b0);
    rd_reg(fa(5'h6));
    `CHK("pred base", 32'h0000_0100, rd)
    issue(enc(3'h4, 1'b1, 5'h5, 5'h6, 5'h1, 4'h9, 1'b0, ST_WORD, 1'b0), 1'b1);
    rd_reg(fa(5'h6));
    `CHK("inv base", 32'h0000_0104, rd)
    `CHK("inv addr", 32'h0000_0104, s_addr)
    issue(enc(3'h0, 1'b0, 5'h5, 5'h6, 5'h1, 4'h9, 1'b0, 3'h1, 1'b0), 1'b0);
    rd_reg(REG_STATUS);
    `CHK("status", 32'h1, rd)
    rd_reg(REG_COUNT);
    `CHK("count", 32'h15, rd)
    rd_reg(REG_LAST_ADDR);
    `CHK("last addr", 32'h0000_0104, rd)
    // Misaligned word still goes out; only the status bit records it
    wr(fa(5'h7), 32'h0000_0102);
    issue(enc(3'h0, 1'b0, 5'h5, 5'h7, 5'h0, 4'h1, 1'b0, ST_WORD, 1'b0), 1'b1);
    `CHK("misaligned addr", 32'h0000_0102, s_addr)
    rd_reg(REG_STATUS);
    `CHK("status both", 32'h3, rd)
    wr(REG_STATUS, 32'h3);
    rd_reg(REG_STATUS);
    `CHK("status clear", 32'h0, rd)
    issue(enc(3'h0, 1'b0, 5'h5, 5'h6, 5'h1, 4'h9, 1'b0, ST_WORD, 1'b0) & ~32'hC, 1'b0);
    rd_reg(REG_STATUS);
    `CHK("bad form", 32'h1, rd)
  endtask : t_pred

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_types();
    t_modes();
    t_long();
    t_circ();
    t_pred();
    close_out();
  end
endmodule : store_address_generator_tb
